// ==== hdl/acs_consts.vh ====
// Purpose: constants of the conversion sequencer
// Assumes: byte-wide registers at their printed offsets
// Notes: definitions only
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_ADDR_W 5
`define ACS_OFF_STATUS 5'h06
`define ACS_OFF_DBG 5'h07
`define ACS_OFF_SAMPTIME 5'h08
`define ACS_OFF_ACCFMT 5'h09
`define ACS_OFF_CMD 5'h0a
`define ACS_OFF_AMP 5'h0b
`define ACS_OFF_POSSEL 5'h0c
`define ACS_OFF_NEGSEL 5'h0d
`define ACS_OFF_MAIN 5'h00
`define ACS_OFF_FLAGS 5'h05
`define ACS_OFF_RES0 5'h10
`define ACS_OFF_SMP0 5'h14
`define ACS_AMP_RESET 8'h04
`define ACS_MODE_LOW 3'h0
`define ACS_MODE_FULL 3'h1
`define ACS_MODE_SER 3'h2
`define ACS_MODE_SERSC 3'h3
`define ACS_MODE_BUR 3'h4
`define ACS_MODE_BURSC 3'h5
`define ACS_START_STOP 3'h0
`define ACS_START_NOW 3'h1
`define ACS_START_POS 3'h2
`define ACS_START_NEG 3'h3
`define ACS_START_EVT 3'h4
`define ACS_ACC_MAX 4'ha
`define ACS_AMP_T0 8'h06
`define ACS_AMP_T1 8'h0f
`define ACS_AMP_T2 8'h14
`define ACS_CONV_LOW 8'h08
`define ACS_CONV_FULL 8'h0c
`define ACS_FLAG_RDY 0
`define ACS_FLAG_SRDY 1
`define ACS_FLAG_TOVR 5
`endif

// ==== hdl/acs_timer.v ====
// Purpose: phase down-counter of the conversion sequencer
// Assumes: load and run are mutually timed by the caller
// Notes: done pulses one cycle when the count reaches one
`timescale 1ns/10ps
module acs_timer (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire load_i,
  input wire [9:0] count_i,
  input wire run_i,
  output wire done_o
);
  reg [9:0] cnt_r;
  reg act_r;
  assign done_o = act_r && run_i && (cnt_r == 10'h001);
  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_r <= 10'h000;
      act_r <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_r <= (count_i == 10'h000) ? 10'h001 : count_i;
      act_r <= 1'b1;
    end
    else if (act_r && run_i)
    begin
      cnt_r <= cnt_r - 10'h001;
      if (cnt_r == 10'h001)
        act_r <= 1'b0;
    end
  end
endmodule

// ==== hdl/acs_sequencer.v ====
// Purpose: control and sequencing of an analog-to-digital converter
// Assumes: one clock used as converter clock; sample data from analog core
// Notes: half cycle of sampling realised as a full cycle of this clock
`timescale 1ns/10ps
`include "acs_consts.vh"
// Functional notes
// - busy is high during conversion, settling or an unfinished burst, low only when all three end
// - halt without run-in-debug stops after current conversion or burst
// - with run-in-debug set, halt does not stop conversions
// - direct sampling lasts sample count plus half a cycle
// - amplified sampling lasts count plus one, then amplifier sample time
// - continuous mode relaunches right after a conversion or accumulation ends
// - left-align bit selects left aligned output
// - accumulation code selects 1 to 1024 samples in powers of two
// - each newest sample goes to the sample register
// - differential bit selects signed two-input conversion
// - mode 0 is one 8-bit conversion, mode 1 one 12-bit
// - series modes take a trigger per conversion and accumulate, 3 scales
// - burst modes run all conversions from one trigger, 5 scales
// - accumulator cleared when switching from accumulating to single mode
// - start code 0 halts a conversion in progress
// - start code 1 converts now and reverts to stop unless continuous
// - codes 2 and 3 start on positive or negative select writes
// - code 4 starts on each incoming event
// - start_now_code start while disabled forces start field to stop
// - trigger during a conversion sets the overrun flag
// - completion sets result-ready; reading the result clears it
// - amplifier sample time codes 0..2 give 6, 15, 20 cycles
// - input routing field is shared by both input select registers
module acs_sequencer (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [4:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire dbg_halt_i,
  input wire event_i,
  input wire settle_i,
  input wire [11:0] adc_data_i,
  output wire sampling_o,
  output wire amp_sampling_o,
  output wire converting_o,
  output reg differential_o,
  output reg output_left_align_o,
  output reg scale_o,
  output reg [1:0] via_o,
  output reg [5:0] pos_sel_o,
  output reg [5:0] neg_sel_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SAMP = 2'h1;
  localparam ST_AMP = 2'h2;
  localparam ST_CONV = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg halt_run_enable_r;
  reg [7:0] sample_time_count_r;
  reg continuous_conversion_r;
  reg [3:0] accumulation_count_select_r;
  reg [2:0] mode_r;
  reg [2:0] start_r;
  reg [7:0] amp_ctrl_r;
  reg main_enable_r;
  reg [10:0] acc_num_r;
  reg [31:0] acc_r;
  reg [31:0] result_r;
  reg [15:0] sample_r;
  reg result_ready_flag_r;
  reg sample_ready_flag_r;
  reg trigger_overrun_flag_r;
  reg burst_r;
  reg [9:0] load_cnt;
  wire timer_done;
  wire timer_load;
  wire trig;
  wire busy;
  wire run_ok;
  wire accum_mode;
  wire [2:0] wmode;
  wire [10:0] target;
  wire [31:0] acc_sum;
  wire seq_end;
  wire [11:0] smp_val;
  wire amp_used;

  assign amp_used = (via_o == 2'h1) && amp_ctrl_r[0];
  assign accum_mode = (mode_r >= `ACS_MODE_SER) && (mode_r <= `ACS_MODE_BURSC);
  assign wmode = wdata_i[6:4];
  assign target = (11'h001 << accumulation_count_select_r);
  assign busy = (state_r != ST_IDLE) || settle_i || burst_r;
  // halt only between conversions and bursts
  assign run_ok = halt_run_enable_r || !dbg_halt_i || (state_r != ST_IDLE) || burst_r;
  assign trig = main_enable_r &&
    (((start_r == `ACS_START_NOW) && !busy) ||
     (start_r == `ACS_START_POS && wr_i && addr_i == `ACS_OFF_POSSEL) ||
     (start_r == `ACS_START_NEG && wr_i && addr_i == `ACS_OFF_NEGSEL) ||
     (start_r == `ACS_START_EVT && event_i));
  assign sampling_o = (state_r == ST_SAMP);
  assign amp_sampling_o = (state_r == ST_AMP);
  assign converting_o = (state_r == ST_CONV);
  assign smp_val = (mode_r == `ACS_MODE_LOW) ? {4'h0, adc_data_i[11:4]} : adc_data_i;
  assign acc_sum = acc_r + {20'h00000, smp_val};
  assign seq_end = (state_r == ST_CONV) && timer_done &&
    (!accum_mode || (acc_num_r + 11'h001 >= target));
  assign timer_load = (state_nxt != state_r) && (state_nxt != ST_IDLE);

  always @*
  begin
    case (state_nxt)
      ST_SAMP: load_cnt = amp_used ? {2'b00, sample_time_count_r} + 10'h001
                                   : {2'b00, sample_time_count_r} + 10'h001;
      ST_AMP:
        case (amp_ctrl_r[2:1])
          2'h0: load_cnt = {2'b00, `ACS_AMP_T0};
          2'h1: load_cnt = {2'b00, `ACS_AMP_T1};
          default: load_cnt = {2'b00, `ACS_AMP_T2};
        endcase
      ST_CONV: load_cnt = (mode_r == `ACS_MODE_LOW) ? {2'b00, `ACS_CONV_LOW}
                                                    : {2'b00, `ACS_CONV_FULL};
      default: load_cnt = 10'h000;
    endcase
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (run_ok && !settle_i && (trig || burst_r))
          state_nxt = ST_SAMP;
      ST_SAMP:
        if (timer_done)
          state_nxt = amp_used ? ST_AMP : ST_CONV;
      ST_AMP:
        if (timer_done)
          state_nxt = ST_CONV;
      ST_CONV:
        if (timer_done)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
    if (wr_i && addr_i == `ACS_OFF_CMD && wdata_i[2:0] == `ACS_START_STOP)
      state_nxt = ST_IDLE;
  end

  acs_timer u_timer (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .load_i(timer_load),
    .count_i(load_cnt),
    .run_i(1'b1),
    .done_o(timer_done)
  );

  always @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= ST_IDLE;
      halt_run_enable_r <= 1'b0;
      sample_time_count_r <= 8'h00;
      continuous_conversion_r <= 1'b0;
      output_left_align_o <= 1'b0;
      accumulation_count_select_r <= 4'h0;
      differential_o <= 1'b0;
      mode_r <= `ACS_MODE_LOW;
      start_r <= `ACS_START_STOP;
      amp_ctrl_r <= `ACS_AMP_RESET;
      main_enable_r <= 1'b0;
      via_o <= 2'h0;
      pos_sel_o <= 6'h00;
      neg_sel_o <= 6'h00;
      acc_num_r <= 11'h000;
      acc_r <= 32'h00000000;
      result_r <= 32'h00000000;
      sample_r <= 16'h0000;
      result_ready_flag_r <= 1'b0;
      sample_ready_flag_r <= 1'b0;
      trigger_overrun_flag_r <= 1'b0;
      burst_r <= 1'b0;
      scale_o <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (wr_i)
      begin
        case (addr_i)
          `ACS_OFF_MAIN: main_enable_r <= wdata_i[0];
          `ACS_OFF_DBG: halt_run_enable_r <= wdata_i[0];
          `ACS_OFF_SAMPTIME: sample_time_count_r <= wdata_i;
          `ACS_OFF_ACCFMT:
          begin
            continuous_conversion_r <= wdata_i[5];
            output_left_align_o <= wdata_i[4];
            accumulation_count_select_r <= (wdata_i[3:0] > `ACS_ACC_MAX) ?
              accumulation_count_select_r : wdata_i[3:0];
          end
          `ACS_OFF_CMD:
          begin
            differential_o <= wdata_i[7];
            if (wmode <= `ACS_MODE_BURSC)
            begin
              mode_r <= wmode;
              scale_o <= (wmode == `ACS_MODE_SERSC) || (wmode == `ACS_MODE_BURSC);
              if (accum_mode && wmode <= `ACS_MODE_FULL)
              begin
                acc_r <= 32'h00000000;
                acc_num_r <= 11'h000;
              end
            end
            if (wdata_i[2:0] == `ACS_START_NOW && !main_enable_r)
              start_r <= `ACS_START_STOP;
            else if (wdata_i[2:0] <= `ACS_START_EVT)
              start_r <= wdata_i[2:0];
            if (wdata_i[2:0] == `ACS_START_STOP)
              burst_r <= 1'b0;
          end
          `ACS_OFF_AMP: amp_ctrl_r <= wdata_i;
          `ACS_OFF_POSSEL:
          begin
            via_o <= wdata_i[7:6];
            pos_sel_o <= wdata_i[5:0];
          end
          `ACS_OFF_NEGSEL:
          begin
            via_o <= wdata_i[7:6];
            neg_sel_o <= wdata_i[5:0];
          end
          default: ;
        endcase
      end
      if (wr_i && addr_i == `ACS_OFF_FLAGS)
      begin
        if (wdata_i[`ACS_FLAG_RDY])
          result_ready_flag_r <= 1'b0;
        if (wdata_i[`ACS_FLAG_SRDY])
          sample_ready_flag_r <= 1'b0;
        if (wdata_i[`ACS_FLAG_TOVR])
          trigger_overrun_flag_r <= 1'b0;
      end
      if (rd_i && addr_i == `ACS_OFF_RES0)
        result_ready_flag_r <= 1'b0;
      if (rd_i && addr_i == `ACS_OFF_SMP0)
        sample_ready_flag_r <= 1'b0;
      if (trig && (state_r != ST_IDLE || burst_r) && start_r != `ACS_START_NOW)
        trigger_overrun_flag_r <= 1'b1;
      if (state_r == ST_IDLE && state_nxt == ST_SAMP && !burst_r &&
          (mode_r == `ACS_MODE_BUR || mode_r == `ACS_MODE_BURSC) && target != 11'h001)
        burst_r <= 1'b1;
      if ((state_r == ST_CONV) && timer_done)
      begin
        sample_r <= {4'h0, smp_val};
        sample_ready_flag_r <= 1'b1;
        if (accum_mode)
        begin
          if (seq_end)
          begin
            result_r <= acc_sum;
            acc_r <= 32'h00000000;
            acc_num_r <= 11'h000;
            burst_r <= 1'b0;
          end
          else
          begin
            acc_r <= acc_sum;
            acc_num_r <= acc_num_r + 11'h001;
          end
        end
        else
          result_r <= {20'h00000, smp_val};
        if (seq_end)
        begin
          result_ready_flag_r <= 1'b1;
          if (start_r == `ACS_START_NOW && !continuous_conversion_r)
            start_r <= `ACS_START_STOP;
          else if (continuous_conversion_r && start_r != `ACS_START_NOW)
            start_r <= `ACS_START_NOW;
        end
      end
      rdata_o <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          `ACS_OFF_MAIN: rdata_o <= {7'h00, main_enable_r};
          `ACS_OFF_FLAGS: rdata_o <= {2'b00, trigger_overrun_flag_r, 3'b000,
                                      sample_ready_flag_r, result_ready_flag_r};
          `ACS_OFF_STATUS: rdata_o <= {7'h00, busy};
          `ACS_OFF_DBG: rdata_o <= {7'h00, halt_run_enable_r};
          `ACS_OFF_SAMPTIME: rdata_o <= sample_time_count_r;
          `ACS_OFF_ACCFMT: rdata_o <= {2'b00, continuous_conversion_r,
                                       output_left_align_o, accumulation_count_select_r};
          `ACS_OFF_CMD: rdata_o <= {differential_o, mode_r, 1'b0, start_r};
          `ACS_OFF_AMP: rdata_o <= amp_ctrl_r;
          `ACS_OFF_POSSEL: rdata_o <= {via_o, pos_sel_o};
          `ACS_OFF_NEGSEL: rdata_o <= {via_o, neg_sel_o};
          5'h10: rdata_o <= result_r[7:0];
          5'h11: rdata_o <= result_r[15:8];
          5'h12: rdata_o <= result_r[23:16];
          5'h13: rdata_o <= result_r[31:24];
          5'h14: rdata_o <= sample_r[7:0];
          5'h15: rdata_o <= sample_r[15:8];
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== dv/acs_sequencer_assertions.sv ====
// Purpose: port-level checks of the conversion sequencer
// Assumes: shadow copies follow register writes on the bus
// Notes: phase lengths are not judged when a write ended the phase
`timescale 1ns/10ps
module acs_sequencer_assertions (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [4:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire settle_i,
  input wire sampling_o,
  input wire amp_sampling_o,
  input wire converting_o,
  input wire differential_o,
  input wire output_left_align_o,
  input wire [1:0] via_o,
  input wire scale_o,
  input wire [5:0] pos_sel_o,
  input wire [5:0] neg_sel_o
);
  reg [7:0] samp_r;
  reg [2:0] mode_r;
  reg [1:0] amp_r;
  reg [8:0] slen_r;
  reg [4:0] alen_r;
  reg [3:0] clen_r;
  wire idle = !sampling_o && !amp_sampling_o && !converting_o;
  wire cmd_ok = wr_i && addr_i == 5'h0a && wdata_i[6:4] < 3'h6 && wdata_i[2:0] < 3'h5;
  always @(posedge core_clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      samp_r <= 8'h00;
      mode_r <= 3'h0;
      amp_r <= 2'h2;
      slen_r <= 9'h000;
      alen_r <= 5'h00;
      clen_r <= 4'h0;
    end
    else
    begin
      slen_r <= sampling_o ? slen_r + 9'h001 : 9'h000;
      alen_r <= amp_sampling_o ? alen_r + 5'h01 : 5'h00;
      clen_r <= converting_o ? clen_r + 4'h1 : 4'h0;
      if (wr_i && addr_i == 5'h08)
        samp_r <= wdata_i;
      if (wr_i && addr_i == 5'h0a && wdata_i[6:4] < 3'h6)
        mode_r <= wdata_i[6:4];
      if (wr_i && addr_i == 5'h0b)
        amp_r <= wdata_i[2:1];
    end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  unmapped_read_a: assert property (
    rd_i && addr_i == 5'h1f |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  left_align_a: assert property (
    wr_i && addr_i == 5'h09 |=> output_left_align_o == $past(wdata_i[4]))
    else $error("left align output wrong");
  via_shared_a: assert property (
    wr_i && (addr_i == 5'h0c || addr_i == 5'h0d) && !wdata_i[7] |=> via_o == $past(wdata_i[7:6]))
    else $error("routing field not shared");
  differential_select_select_a: assert property (
    cmd_ok |=> differential_o == $past(wdata_i[7])) else $error("differential output wrong");
  sample_len_a: assert property (
    $fell(sampling_o) && !$past(wr_i) && !idle |-> slen_r == samp_r + 9'h001)
    else $error("sampling length wrong");
  conv_len_a: assert property (
    $fell(converting_o) && !$past(wr_i) |-> clen_r == (mode_r == 3'h0 ? 4'h8 : 4'hc))
    else $error("conversion length wrong");
  amp_len_a: assert property (
    $fell(amp_sampling_o) && !$past(wr_i)
    |-> alen_r == (amp_r == 2'h0 ? 5'h06 : amp_r == 2'h1 ? 5'h0f : 5'h14))
    else $error("amplifier sampling length wrong");
  busy_status_a: assert property (
    rd_i && addr_i == 5'h06 && (settle_i || !idle) |=> rdata_o == 8'h01)
    else $error("busy flag not shown");
  scale_out_a: assert property (
    wr_i && addr_i == 5'h0a && wdata_i[6:4] < 3'h6
    |=> scale_o == ($past(wdata_i[6:4]) == 3'h3 || $past(wdata_i[6:4]) == 3'h5))
    else $error("scaling output wrong");
  pos_select_a: assert property (
    wr_i && addr_i == 5'h0c |=> pos_sel_o == $past(wdata_i[5:0]))
    else $error("positive input select wrong");
  neg_select_a: assert property (
    wr_i && addr_i == 5'h0d |=> neg_sel_o == $past(wdata_i[5:0]))
    else $error("negative input select wrong");
  cover property ($fell(amp_sampling_o));
  cover property ($fell(converting_o) && mode_r == 3'h4);
  cover property (rd_i && addr_i == 5'h06 && !idle);
endmodule

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench of the conversion sequencer
// Assumes: analog data held steady across each conversion
// Notes: reads queue mask and value; a monitor compares a cycle later
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module tb_top;
  reg core_clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg [4:0] addr_i = 5'h00;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg dbg_halt_i = 1'b0;
  reg event_i = 1'b0;
  reg settle_i = 1'b0;
  reg [11:0] adc_data_i = 12'h000;
  wire [7:0] rdata_o;
  wire sampling_o, amp_sampling_o, converting_o, differential_o, output_left_align_o;
  wire [1:0] via_o;
  integer num_errors = 0;
  integer total_checks = 0;
  integer seed = 51467;
  integer i;
  reg [31:0] v;
  reg [15:0] q[$];
  reg [15:0] e;
  reg rd_seen = 1'b0;
  wire act = sampling_o | amp_sampling_o | converting_o;
  always #10 core_clk_i = ~core_clk_i;
  acs_sequencer dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dbg_halt_i(dbg_halt_i),
    .event_i(event_i), .settle_i(settle_i), .adc_data_i(adc_data_i), .sampling_o(sampling_o),
    .amp_sampling_o(amp_sampling_o), .converting_o(converting_o),
    .differential_o(differential_o), .output_left_align_o(output_left_align_o),
    .scale_o(), .via_o(via_o), .pos_sel_o(), .neg_sel_o());
  task bus(input w, input r, input t, input [4:0] a, input [7:0] d, input [7:0] m);
  begin
    wr_i <= w;
    rd_i <= r;
    event_i <= t;
    addr_i <= a;
    wdata_i <= d;
    if (r)
      q.push_back({m, d});
    @(posedge core_clk_i);
  end
  endtask
  task wr(input [4:0] a, input [7:0] d); bus(1'b1, 1'b0, 1'b0, a, d, 8'h00); endtask
  task rd(input [4:0] a, input [7:0] m, input [7:0] x); bus(1'b0, 1'b1, 1'b0, a, x, m); endtask
  task ev; bus(1'b0, 1'b0, 1'b1, 5'h00, 8'h00, 8'h00); endtask
  task idle(input integer n); repeat (n) bus(1'b0, 1'b0, 1'b0, 5'h00, 8'h00, 8'h00); endtask
  task wt;
    integer n;
    integer k;
  begin
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    event_i <= 1'b0;
    k = 0;
    repeat (2) @(negedge core_clk_i);
    `CHK("active", 1'b1, act)
    // a burst idles one cycle between conversions
    for (n = 0; n < 3000 && k < 2; n++)
    begin
      @(negedge core_clk_i);
      k = act ? 0 : k + 1;
    end
    `CHK("idle", 1'b0, act)
    @(posedge core_clk_i);
  end
  endtask
  task wrap_up;
  begin
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  always @(posedge core_clk_i)
    rd_seen <= rd_i;
  always @(negedge core_clk_i)
    if (rd_seen)
    begin
      e = q.pop_front();
      `CHK("rdata", e[7:0], rdata_o & e[15:8])
    end
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    wrap_up;
  end
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (i = 6; i < 12; i++)
      rd(i[4:0], 8'hff, (i == 11) ? 8'h04 : 8'h00);
    rd(5'h1f, 8'hff, 8'h00);
    for (i = 0; i < 11; i++)
    begin
      v = $random(seed);
      wr(5'h09, {v[7:4], i[3:0]});
      rd(5'h09, 8'hff, {2'h0, v[5:4], i[3:0]});
      wr(5'h07, v[15:8]);
      rd(5'h07, 8'hff, {7'h00, v[8]});
      wr(5'h0c, {1'b0, v[22:16]});
      rd(5'h0d, 8'hc0, {1'b0, v[22], 6'h00});
      wr(5'h0a, {v[23], 3'(i % 6), 4'h4});
      rd(5'h0a, 8'hff, {v[23], 3'(i % 6), 4'h4});
      wr(5'h08, v[31:24]);
      rd(5'h08, 8'hff, v[31:24]);
    end
    wr(5'h09, 8'h0b);
    rd(5'h09, 8'h0f, 8'h0a);
    wr(5'h0a, 8'h64);
    rd(5'h0a, 8'h70, 8'h40);
    wr(5'h09, 8'h00);
    wr(5'h08, 8'h03);
    wr(5'h0b, 8'h03);
    rd(5'h0b, 8'hff, 8'h03);
    settle_i <= 1'b1;
    idle(2);
    rd(5'h06, 8'hff, 8'h01);
    settle_i <= 1'b0;
    wr(5'h0a, 8'h11);
    rd(5'h0a, 8'h07, 8'h00);
    wr(5'h00, 8'h01);
    adc_data_i <= v[11:0];
    wr(5'h0a, 8'h11);
    wt;
    rd(5'h0a, 8'hff, 8'h10);
    rd(5'h05, 8'h03, 8'h03);
    rd(5'h10, 8'hff, v[7:0]);
    rd(5'h11, 8'hff, {4'h0, v[11:8]});
    rd(5'h05, 8'h01, 8'h00);
    wr(5'h0a, 8'h01);
    wt;
    rd(5'h10, 8'hff, v[11:4]);
    wr(5'h09, 8'h02);
    wr(5'h0a, 8'h41);
    wt;
    rd(5'h10, 8'hff, {v[5:0], 2'h0});
    rd(5'h11, 8'hff, {2'h0, v[11:6]});
    rd(5'h14, 8'hff, v[7:0]);
    wr(5'h09, 8'h20);
    wr(5'h0a, 8'h11);
    idle(1);
    rd(5'h06, 8'hff, 8'h01);
    idle(60);
    rd(5'h0a, 8'h07, 8'h01);
    wr(5'h0a, 8'h10);
    rd(5'h06, 8'hff, 8'h00);
    wr(5'h09, 8'h00);
    wr(5'h05, 8'h23);
    wr(5'h0a, 8'h12);
    wr(5'h0c, 8'h45);
    wt;
    wr(5'h0a, 8'h13);
    wr(5'h0d, 8'h42);
    wt;
    wr(5'h09, 8'h01);
    wr(5'h0a, 8'h22);
    wr(5'h0c, 8'h45);
    wt;
    wr(5'h0a, 8'h12);
    wr(5'h0a, 8'h22);
    wr(5'h05, 8'h01);
    wr(5'h0c, 8'h45);
    wt;
    rd(5'h05, 8'h01, 8'h00);
    wr(5'h0c, 8'h45);
    wt;
    rd(5'h10, 8'hff, {v[6:0], 1'b0});
    rd(5'h11, 8'hff, {3'h0, v[11:7]});
    dbg_halt_i <= 1'b1;
    wr(5'h07, 8'h00);
    wr(5'h0a, 8'h14);
    ev;
    idle(2);
    rd(5'h06, 8'hff, 8'h00);
    wr(5'h07, 8'h01);
    ev;
    idle(2);
    ev;
    wt;
    rd(5'h05, 8'h20, 8'h20);
    idle(2);
    wrap_up;
  end
endmodule
bind acs_sequencer acs_sequencer_assertions chk (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .settle_i(settle_i), .sampling_o(sampling_o),
  .amp_sampling_o(amp_sampling_o), .converting_o(converting_o),
  .differential_o(differential_o), .output_left_align_o(output_left_align_o), .via_o(via_o),
  .scale_o(scale_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o));
